// >>> hw/pcemux_pkg.sv
// package for the combined port read-source multiplexer
// What this block does
// RQ1: no comparator or op-amp: plain I/O
// RQ2: comp one, bit1 zero off: pin1 read
// RQ3: comp one set: bit0 reads comparator one
// RQ4: comp one, bit1 zero on: bit1 reads 0
// RQ5: comp two, bit3 zero off: pin3 read
// RQ6: comp two set: bit2 reads comparator two
// RQ7: comp two, bit3 zero on: bit3 reads 0
// RQ8: comp plus op-amp: bits 3,2 zero, bit0 comparator
// RQ9: comp plus op-amp: bit1 pin or zero
// RQ10: supplier keeps comp two off then
// RQ11: per-bit wake enables gate halt wake-up
// RQ12: per-bit force-high drives port D outputs high
// RQ13: read-zero options act only with comparator
// RQ14: direction bit 1 output, 0 input
// RQ15: static options, combinational read select
package pcemux_pkg;
	localparam int PORT_W = 4;
	localparam logic [3:0] DIR_RESET = 4'h0;
	localparam logic [3:0] DATA_RESET = 4'h0;
	localparam int B_CMP1 = 0;
	localparam int B_PIN1 = 1;
	localparam int B_CMP2 = 2;
	localparam int B_PIN3 = 3;
	localparam logic [3:0] REG_DIRECTION = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h4;
	localparam logic [3:0] REG_PORT_D_OUT = 4'hD;

	typedef struct packed {
		logic comparator_one_option;
		logic comparator_two_option;
		logic opamp_option;
		logic bit1_read_zero_option;
		logic bit3_read_zero_option;
	} pcemux_opt_type;

	typedef struct packed {
		logic [3:0] port_a_wake_enable;
		logic [3:0] port_b_wake_enable;
		logic [3:0] port_d_wake_enable;
		logic [3:0] port_e_wake_enable;
		logic [3:0] port_d_force_high;
	} pcemux_fuse_type;
endpackage

// >>> hw/pcemux_sync.sv
// two-flop synchroniser vector
`timescale 1ns/100ps
module pcemux_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,     // system clock
	input  wire logic         rst_n,   // synced reset
	input  wire logic [W-1:0] d_async, // asynchronous input
	output logic      [W-1:0] q_sync   // synchronised copy
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q_sync   <= '0;
		end
		else
		begin
			meta_reg <= d_async;
			q_sync   <= meta_reg;
		end
	end
endmodule

// >>> hw/pcemux_top.sv
// combined port CE read mux, direction, wake and port D force high
`timescale 1ns/100ps
module pcemux_top
	import pcemux_pkg::*;
(
	input  wire logic            clk,            // 200 MHz clock
	input  wire logic            nrst,           // async reset, low
	input  wire pcemux_opt_type  opt,            // static option fuses
	input  wire pcemux_fuse_type fuse,           // static wake/force fuses
	input  wire logic [3:0]      addr,           // register address
	input  wire logic [3:0]      wdata,          // write data
	input  wire logic            wr,             // write strobe
	input  wire logic            rd,             // read strobe
	output logic      [3:0]      rdata,          // read data, next cycle
	input  wire logic [3:0]      pce_pin_in,     // port CE pin levels
	output logic      [3:0]      pce_pin_out,    // port CE pin drive
	output logic      [3:0]      pce_pin_oe,     // port CE output enable
	input  wire logic            cmp1_out,       // comparator one output
	input  wire logic            cmp2_out,       // comparator two output
	output logic      [3:0]      port_d_out,     // port D output value
	input  wire logic [3:0]      port_a_pin,     // port A pins
	input  wire logic [3:0]      port_b_pin,     // port B pins
	input  wire logic [3:0]      port_d_pin,     // port D pins
	input  wire logic [3:0]      port_e_pin,     // port E pins
	input  wire logic            halted,         // cpu is in halt
	output logic                 wake_reg        // wake-up pulse
);
	////////////////////////////////////////////////////////////////////
	logic       rst_meta_reg;
	logic       rst_n;
	logic [3:0] pce_s;
	logic [1:0] cmp_s;
	logic [15:0] wk_s;
	logic [15:0] wk_prev_reg;
	logic [3:0] dir_reg;
	logic [3:0] data_reg;
	logic [3:0] pd_reg;
	logic [3:0] ce_read;
	logic       plain_io;
	logic [15:0] wk_en;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	pcemux_sync #(.W(4)) u_pce_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.d_async (pce_pin_in),
		.q_sync  (pce_s)
	);

	pcemux_sync #(.W(2)) u_cmp_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.d_async ({cmp2_out, cmp1_out}),
		.q_sync  (cmp_s)
	);

	pcemux_sync #(.W(16)) u_wk_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.d_async ({port_e_pin, port_d_pin, port_b_pin, port_a_pin}),
		.q_sync  (wk_s)
	);

	////////////////////////////////////////////////////////////////////
	// read source select; options are static so no state needed
	always_comb
	begin
		plain_io = !opt.comparator_one_option && !opt.comparator_two_option
			&& !opt.opamp_option; // RQ1
		// io ports read pin in input mode, latch in output mode
		for (int i = 0; i < PORT_W; i++)
			ce_read[i] = dir_reg[i] ? data_reg[i] : pce_s[i];
		if (opt.comparator_one_option)
		begin
			ce_read[B_CMP1] = cmp_s[0]; // RQ3 RQ15
			ce_read[B_PIN1] = opt.bit1_read_zero_option ? 1'b0 : pce_s[B_PIN1]; // RQ2 RQ4 RQ13
		end
		if (opt.comparator_two_option)
		begin
			ce_read[B_CMP2] = cmp_s[1]; // RQ6
			ce_read[B_PIN3] = opt.bit3_read_zero_option ? 1'b0 : pce_s[B_PIN3]; // RQ5 RQ7 RQ13
		end
		// op-amp uses bits 3,2 as analog inputs (comp two off per RQ10)
		if (opt.opamp_option && opt.comparator_one_option && !opt.comparator_two_option)
		begin
			ce_read[B_CMP2] = 1'b0; // RQ8
			ce_read[B_PIN3] = 1'b0; // RQ8
			ce_read[B_PIN1] = opt.bit1_read_zero_option ? 1'b0 : pce_s[B_PIN1]; // RQ9
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_reg  <= DIR_RESET;
			data_reg <= DATA_RESET;
			pd_reg   <= DATA_RESET;
		end
		else if (wr)
		begin
			if (addr == REG_DIRECTION)
				dir_reg <= wdata; // RQ14
			if (addr == REG_DATA)
				data_reg <= wdata;
			if (addr == REG_PORT_D_OUT)
				pd_reg <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 4'h0;
		else if (rd)
		begin
			unique case (addr)
				REG_DIRECTION:  rdata <= dir_reg;
				REG_DATA:       rdata <= ce_read;
				REG_PORT_D_OUT: rdata <= pd_reg;
				default:        rdata <= 4'h0;
			endcase
		end
		else
			rdata <= 4'h0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pce_pin_out <= 4'h0;
			pce_pin_oe  <= 4'h0;
			port_d_out  <= 4'h0;
		end
		else
		begin
			pce_pin_out <= data_reg;
			pce_pin_oe  <= dir_reg; // RQ14
			port_d_out  <= pd_reg | fuse.port_d_force_high; // RQ12
		end
	end

	////////////////////////////////////////////////////////////////////
	// rising edge on an enabled pin wakes from halt
	assign wk_en = {fuse.port_e_wake_enable, fuse.port_d_wake_enable,
		fuse.port_b_wake_enable, fuse.port_a_wake_enable};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wk_prev_reg <= 16'h0000;
			wake_reg    <= 1'b0;
		end
		else
		begin
			wk_prev_reg <= wk_s;
			wake_reg    <= halted && |(wk_s & ~wk_prev_reg & wk_en); // RQ11
		end
	end

	////////////////////////////////////////////////////////////////////
	property p_bit0_cmp;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_one_option |=> rdata[0] == $past(cmp_s[0]);
	endproperty
	a_bit0_cmp: assert property (p_bit0_cmp) else $error("bit0 not comparator one"); // RQ3

	property p_bit2_cmp;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_two_option |=> rdata[2] == $past(cmp_s[1]);
	endproperty
	a_bit2_cmp: assert property (p_bit2_cmp) else $error("bit2 not comparator two"); // RQ6

	property p_b1_zero;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_one_option && opt.bit1_read_zero_option
		|=> rdata[1] == 1'b0;
	endproperty
	a_b1_zero: assert property (p_b1_zero) else $error("bit1 not zero"); // RQ4

	property p_b1_pin;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_one_option && !opt.bit1_read_zero_option
		|=> rdata[1] == $past(pce_s[1]);
	endproperty
	a_b1_pin: assert property (p_b1_pin) else $error("bit1 not pin"); // RQ2

	property p_b3_zero;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_two_option && opt.bit3_read_zero_option
		|=> rdata[3] == 1'b0;
	endproperty
	a_b3_zero: assert property (p_b3_zero) else $error("bit3 not zero"); // RQ7

	property p_b3_pin;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.comparator_two_option && !opt.bit3_read_zero_option
		|=> rdata[3] == $past(pce_s[3]);
	endproperty
	a_b3_pin: assert property (p_b3_pin) else $error("bit3 not pin"); // RQ5

	property p_opamp_hi;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.opamp_option && opt.comparator_one_option
		&& !opt.comparator_two_option |=> rdata[3:2] == 2'b00;
	endproperty
	a_opamp_hi: assert property (p_opamp_hi) else $error("op-amp bits not zero"); // RQ8

	property p_force;
		@(posedge clk) disable iff (!rst_n)
		##1 1'b1 |-> (port_d_out & fuse.port_d_force_high) == fuse.port_d_force_high;
	endproperty
	a_force: assert property (p_force) else $error("force high not applied"); // RQ12

	property p_wake;
		@(posedge clk) disable iff (!rst_n)
		wake_reg |-> $past(halted) && |($past(wk_s) & ~$past(wk_prev_reg) & wk_en);
	endproperty
	a_wake: assert property (p_wake) else $error("wake from disabled pin"); // RQ11

	property p_plain;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && plain_io && dir_reg == 4'h0 |=> rdata == $past(pce_s);
	endproperty
	a_plain: assert property (p_plain) else $error("plain io read wrong"); // RQ1

	property p_dir;
		@(posedge clk) disable iff (!rst_n)
		wr && addr == REG_DIRECTION |=> ##1 pce_pin_oe == $past(wdata, 2);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not applied"); // RQ14

	// read-zero options must be ignored while their comparator is off
	property p_b1_plain;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && !opt.comparator_one_option && !dir_reg[1]
		|=> rdata[1] == $past(pce_s[1]);
	endproperty
	a_b1_plain: assert property (p_b1_plain) else $error("bit1 zero without comparator"); // RQ13

	property p_b3_plain;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && !opt.comparator_two_option && !dir_reg[3]
		&& !(opt.opamp_option && opt.comparator_one_option)
		|=> rdata[3] == $past(pce_s[3]);
	endproperty
	a_b3_plain: assert property (p_b3_plain) else $error("bit3 zero without comparator"); // RQ13

	property p_b0_plain;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && !opt.comparator_one_option && !dir_reg[0]
		|=> rdata[0] == $past(pce_s[0]);
	endproperty
	a_b0_plain: assert property (p_b0_plain) else $error("bit0 input not pin"); // RQ1

	property p_b2_plain;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && !opt.comparator_two_option && !dir_reg[2]
		&& !(opt.opamp_option && opt.comparator_one_option)
		|=> rdata[2] == $past(pce_s[2]);
	endproperty
	a_b2_plain: assert property (p_b2_plain) else $error("bit2 input not pin"); // RQ1

	property p_opamp_b0;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.opamp_option && opt.comparator_one_option
		&& !opt.comparator_two_option |=> rdata[0] == $past(cmp_s[0]);
	endproperty
	a_opamp_b0: assert property (p_opamp_b0) else $error("op-amp bit0 not comparator"); // RQ8

	property p_opamp_b1_pin;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.opamp_option && opt.comparator_one_option
		&& !opt.comparator_two_option && !opt.bit1_read_zero_option
		|=> rdata[1] == $past(pce_s[1]);
	endproperty
	a_opamp_b1_pin: assert property (p_opamp_b1_pin) else $error("op-amp bit1 not pin"); // RQ9

	property p_opamp_b1_zero;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && opt.opamp_option && opt.comparator_one_option
		&& !opt.comparator_two_option && opt.bit1_read_zero_option
		|=> rdata[1] == 1'b0;
	endproperty
	a_opamp_b1_zero: assert property (p_opamp_b1_zero) else $error("op-amp bit1 not zero"); // RQ9

	// output bits read back the latch, not the pin
	property p_latch_read;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DATA && plain_io
		|=> ((rdata ^ $past(data_reg)) & $past(dir_reg)) == 4'h0;
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("output bit not latch"); // RQ14

	property p_dir_read;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == REG_DIRECTION |=> rdata == $past(dir_reg);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction read wrong"); // RQ14

	property p_pin_out;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pce_pin_out == $past(data_reg);
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pin drive not latch"); // RQ14

	property p_pin_oe;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pce_pin_oe == $past(dir_reg);
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("drive enable not direction"); // RQ14

	// fuses are static, so no past value is needed for them
	property p_force_exact;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> port_d_out == ($past(pd_reg) | fuse.port_d_force_high);
	endproperty
	a_force_exact: assert property (p_force_exact) else $error("port D output wrong"); // RQ12

	property p_awake;
		@(posedge clk) disable iff (!rst_n)
		!halted |=> !wake_reg;
	endproperty
	a_awake: assert property (p_awake) else $error("wake while running"); // RQ11

	property p_no_edge;
		@(posedge clk) disable iff (!rst_n)
		(wk_s & ~wk_prev_reg & wk_en) == 16'h0000 |=> !wake_reg;
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("wake without enabled edge"); // RQ11
endmodule

// >>> test/pcemux_front.sv
// comparator front end, option supply and port CE pins
`timescale 1ns/100ps
module pcemux_front
	import pcemux_pkg::*;
(
	input  wire logic [3:0]     pin_out,  // block pin drive
	input  wire logic [3:0]     pin_oe,   // block drive enable
	input  wire logic [3:0]     ext_lvl,  // outside pin level
	input  wire logic           cmp1_lvl, // comparator one result
	input  wire logic           cmp2_lvl, // comparator two result
	input  wire pcemux_opt_type opt_raw,  // requested options
	output logic      [3:0]     pin_in,   // resolved pin level
	output logic                cmp1_out, // to block
	output logic                cmp2_out, // to block
	output pcemux_opt_type      opt       // options as supplied
);
	// a driven pin shows the block's value, else the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	assign cmp1_out = cmp1_lvl;
	assign cmp2_out = cmp2_lvl;
	always_comb
	begin
		opt = opt_raw;
		if (opt_raw.opamp_option && opt_raw.comparator_one_option)
			opt.comparator_two_option = 1'b0;
	end
endmodule

// >>> test/test_port_ce_read_source_mux.sv
// self-checking bench for the port CE read-source block
`timescale 1ns/100ps
module test_port_ce_read_source_mux;
	import pcemux_pkg::*;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, c1 = 0, c2 = 0, halted = 0, cmp1_out, cmp2_out, wake_reg;
	logic [3:0] addr = 0, wdata = 0, ext = 0, pa = 0, pin_in, pin_out, pin_oe, rdata, port_d_out;
	pcemux_opt_type  opt_raw = '0, opt;
	pcemux_fuse_type fuse = '{4'h1, 4'h0, 4'h0, 4'h8, 4'h2}; // wake a bit 0, e bit 3; force d bit 1
	int fails = 0, samples_checked = 0, seen;
	always #2.5 clk = ~clk;
	pcemux_top DUT (.clk(clk), .nrst(nrst), .opt(opt), .fuse(fuse), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pce_pin_in(pin_in),
		.pce_pin_out(pin_out), .pce_pin_oe(pin_oe), .cmp1_out(cmp1_out),
		.cmp2_out(cmp2_out), .port_d_out(port_d_out), .port_a_pin(pa),
		.port_b_pin(pa), .port_d_pin(pa), .port_e_pin(pa), .halted(halted),
		.wake_reg(wake_reg));
	pcemux_front front (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .cmp1_lvl(c1),
		.cmp2_lvl(c2), .opt_raw(opt_raw), .pin_in(pin_in), .cmp1_out(cmp1_out),
		.cmp2_out(cmp2_out), .opt(opt));
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// expected read of the combined port data with all bits as inputs
	function automatic logic [3:0] exp_rd(pcemux_opt_type o, logic [3:0] p, logic a, logic b);
		logic [3:0] r;
		r = p;
		if (o.comparator_one_option)
		begin
			r[0] = a;
			r[1] = o.bit1_read_zero_option ? 1'b0 : p[1];
		end
		if (o.comparator_one_option && o.opamp_option)
			r[3:2] = 2'b00;
		else if (o.comparator_two_option)
		begin
			r[2] = b;
			r[3] = o.bit3_read_zero_option ? 1'b0 : p[3];
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		fails++;
		summarize();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		// every option mix, two pin and comparator patterns each
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk);
			opt_raw <= pcemux_opt_type'(i[4:0]);
			ext <= i[5] ? 4'h5 : 4'hA;
			c1 <= ~i[5];
			c2 <= i[5];
			repeat (4) @(posedge clk);
			rd_chk(REG_DATA, exp_rd(pcemux_opt_type'(i[4:0]), i[5] ? 4'h5 : 4'hA, ~i[5], i[5]));
		end
		// pure I/O: direction, latch read-back and pin drive
		@(posedge clk);
		opt_raw <= '0;
		ext <= 4'h0;
		wr_reg(REG_DIRECTION, 4'hF);
		wr_reg(REG_DATA, 4'h6);
		repeat (2) @(posedge clk);
		chk(pin_oe, 4'hF);
		chk(pin_out, 4'h6);
		rd_chk(REG_DIRECTION, 4'hF);
		wr_reg(REG_DIRECTION, 4'h3);
		repeat (4) @(posedge clk);
		chk(pin_oe, 4'h3);
		rd_chk(REG_DATA, 4'h2);
		rd_chk(4'h7, 4'h0);
		// forced-high bits of port D; fuses are static from reset on
		wr_reg(REG_PORT_D_OUT, 4'h5);
		repeat (2) @(posedge clk);
		chk(port_d_out, 4'h7);
		// only an enabled pin wakes the halted core
		halted <= 1'b1;
		seen = 0;
		@(posedge clk);
		pa <= 4'h2;
		repeat (8) @(posedge clk) seen += wake_reg;
		chk(4'(seen), 4'h0);
		pa <= 4'h3;
		repeat (8) @(posedge clk) seen += wake_reg;
		chk(4'(seen), 4'h1);
		// bit 3 rises on all ports, enabled on port E only
		pa <= 4'hB;
		repeat (8) @(posedge clk) seen += wake_reg;
		chk(4'(seen), 4'h2);
		// an enabled edge while running must not wake
		halted <= 1'b0;
		pa <= 4'h0;
		repeat (8) @(posedge clk) seen += wake_reg;
		pa <= 4'h1;
		repeat (8) @(posedge clk) seen += wake_reg;
		chk(4'(seen), 4'h2);
		summarize();
	end
endmodule
